// ### hdl/rsfr_engine.sv
// raw serial send/receive engine with word memory and Avalon-MM slave
`timescale 1ns/1ns
`include "rsfr_regs.svh"
module rsfr_engine #(
    parameter int TICK_CYCLES = `RSFR_TICK_MS * `RSFR_CLK_KHZ
) (
    input  wire logic                clock,
    input  wire logic                sys_rst,
    input  wire logic [10:0]         avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    output logic      [31:0]         avs_readdata,
    output logic                     avs_waitrequest,
    input  wire rsfr_pkg::rsfr_byte_s rxByte,
    output rsfr_pkg::rsfr_byte_s     txByte,
    input  wire logic                txReady,
    output logic                     irq
);
    localparam logic [7:0] DEF_TICKS = 8'(`RSFR_DEF_TMO_MS / `RSFR_TICK_MS);

    // word memory shared by both directions
    logic [15:0] mem [0:255];
    // control and configuration
    logic        run;
    logic        pack;
    logic [15:0] fmt;
    logic [7:0]  startChar;
    logic [7:0]  stopChar;
    logic [7:0]  txBase;
    logic [7:0]  txLen;
    logic [7:0]  rxBase;
    logic [7:0]  rxLen;
    logic [7:0]  tmoSet;
    // flags and state
    logic        txReq;
    logic        rxDone;
    logic        rxTmo;
    logic [7:0]  rxCnt;
    logic [7:0]  txCnt;
    logic [2:0]  irqStat;
    logic [2:0]  irqEn;
    logic [31:0] tickCnt;
    logic [7:0]  idleTicks;
    logic [7:0]  tmoTicks;
    logic        rxFinish;
    logic        tmoHit;
    logic        txDone;
    logic        txFree;
    logic        wrEn;
    logic        rdEn;
    logic [31:0] rdData;
    logic [15:0] txWord;
    rsfr_pkg::rsfr_rx_e rxState;
    rsfr_pkg::rsfr_tx_e txState;

    // address match on whole words
    function automatic logic isAt(input logic [10:0] a, input logic [10:0] o);
        isAt = a[10:2] == o[10:2];
    endfunction

    // memory word holding byte number cnt of a block
    function automatic logic [7:0] wordIdx(input logic [7:0] base, input logic [7:0] cnt,
                                           input logic pk);
        wordIdx = pk ? 8'(base + cnt) : 8'(base + {1'b0, cnt[7:1]});
    endfunction

    // bus strobes: writes act on the edge that sees waitrequest low, reads on the wait edge before it
    assign wrEn = avs_write && !avs_waitrequest;
    assign rdEn = avs_read && avs_waitrequest;

    // one wait cycle per access, then a single ready cycle
    always_ff @(posedge clock) begin
        if (sys_rst)
            avs_waitrequest <= 1'b1;
        else if ((avs_read || avs_write) && avs_waitrequest)
            avs_waitrequest <= 1'b0;
        else
            avs_waitrequest <= 1'b1;
    end

    // configuration registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            run <= 1'b0;
            pack <= 1'b0;
            fmt <= 16'h0000;
            {stopChar, startChar} <= `RSFR_CHAR_RST;
            {txLen, txBase} <= 16'h0000;
            {rxLen, rxBase} <= 16'h0000;
            tmoSet <= `RSFR_TMO_RST;
            irqEn <= 3'h0;
        end else if (wrEn) begin
            if (isAt(avs_address, `RSFR_CTRL_OFS)) begin
                run <= avs_writedata[`RSFR_CTRL_RUN];
                pack <= avs_writedata[`RSFR_CTRL_PACK];
            end
            if (isAt(avs_address, `RSFR_FMT_OFS))
                fmt <= avs_writedata[15:0];
            if (isAt(avs_address, `RSFR_CHAR_OFS))
                {stopChar, startChar} <= avs_writedata[15:0];
            if (isAt(avs_address, `RSFR_TXCFG_OFS))
                {txLen, txBase} <= avs_writedata[15:0];
            if (isAt(avs_address, `RSFR_RXCFG_OFS))
                {rxLen, rxBase} <= avs_writedata[15:0];
            if (isAt(avs_address, `RSFR_TMO_OFS))
                tmoSet <= avs_writedata[7:0];
            if (isAt(avs_address, `RSFR_IRQ_EN_OFS))
                irqEn <= avs_writedata[2:0];
        end
    end

    // read mux; unmapped words read as zero
    always_comb begin
        rdData = 32'h0000_0000;
        if (avs_address >= `RSFR_MEM_OFS)
            rdData = {16'h0000, mem[avs_address[9:2]]};
        else if (isAt(avs_address, `RSFR_CTRL_OFS))
            rdData = {28'h0, 1'b0, txReq, pack, run};
        else if (isAt(avs_address, `RSFR_FMT_OFS))
            rdData = {16'h0000, fmt};
        else if (isAt(avs_address, `RSFR_CHAR_OFS))
            rdData = {16'h0000, stopChar, startChar};
        else if (isAt(avs_address, `RSFR_TXCFG_OFS))
            rdData = {16'h0000, txLen, txBase};
        else if (isAt(avs_address, `RSFR_RXCFG_OFS))
            rdData = {16'h0000, rxLen, rxBase};
        else if (isAt(avs_address, `RSFR_TMO_OFS))
            rdData = {24'h000000, tmoSet};
        else if (isAt(avs_address, `RSFR_STAT_OFS))
            rdData = {27'h0, txState != rsfr_pkg::TX_IDLE,
                      rxState == rsfr_pkg::RX_HUNT || rxState == rsfr_pkg::RX_DATA,
                      txReq, rxTmo, rxDone};
        else if (isAt(avs_address, `RSFR_RXCNT_OFS))
            rdData = {24'h000000, rxCnt};
        else if (isAt(avs_address, `RSFR_IRQ_STAT_OFS))
            rdData = {29'h0, irqStat};
        else if (isAt(avs_address, `RSFR_IRQ_EN_OFS))
            rdData = {29'h0, irqEn};
    end

    // read data loads on the wait edge and stands through the ready cycle
    always_ff @(posedge clock) begin
        if (sys_rst)
            avs_readdata <= 32'h0000_0000;
        else if (rdEn)
            avs_readdata <= rdData;
    end

    // interval in ticks; fallback when out of range
    assign tmoTicks = (tmoSet >= `RSFR_TMO_MIN) ? tmoSet : DEF_TICKS;

    // 10 ms timebase restarted by every received byte
    always_ff @(posedge clock) begin
        if (sys_rst || rxByte.valid || rxState != rsfr_pkg::RX_DATA) begin
            tickCnt <= 32'h0000_0000;
            idleTicks <= 8'h00;
        end else if (tickCnt == 32'(TICK_CYCLES - 1)) begin
            tickCnt <= 32'h0000_0000;
            if (idleTicks != 8'hFF)
                idleTicks <= idleTicks + 8'h01;
        end else begin
            tickCnt <= tickCnt + 32'h0000_0001;
        end
    end

    // gap only counts once a message has started
    assign tmoHit = rxState == rsfr_pkg::RX_DATA && !rxByte.valid && rxCnt != 8'h00
                    && idleTicks >= tmoTicks;
    // stop character or full count ends reception
    assign rxFinish = rxState == rsfr_pkg::RX_DATA && (tmoHit || (rxByte.valid
                      && ((fmt[`RSFR_FMT_STOPEN] && rxByte.data == stopChar)
                      || rxCnt + 8'h01 == rxLen)));

    // receive sequencer
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rxState <= rsfr_pkg::RX_IDLE;
            rxCnt <= 8'h00;
        end else begin
            unique case (rxState)
                // waiting needs run and nonzero length
                rsfr_pkg::RX_IDLE: if (run && rxLen != 8'h00 && !rxDone) begin
                    rxCnt <= 8'h00;
                    rxState <= fmt[`RSFR_FMT_STARTEN] ? rsfr_pkg::RX_HUNT : rsfr_pkg::RX_DATA;
                end
                // skip bytes until the start character
                rsfr_pkg::RX_HUNT: if (!run)
                    rxState <= rsfr_pkg::RX_IDLE;
                else if (rxByte.valid && rxByte.data == startChar)
                    rxState <= rsfr_pkg::RX_DATA;
                rsfr_pkg::RX_DATA: begin
                    if (rxFinish)
                        rxState <= rsfr_pkg::RX_DONE;
                    else if (!run)
                        rxState <= rsfr_pkg::RX_IDLE;
                    // a stop character is not stored or counted
                    if (rxByte.valid && !(fmt[`RSFR_FMT_STOPEN] && rxByte.data == stopChar))
                        rxCnt <= rxCnt + 8'h01;
                end
                // back to waiting once software clears the flag
                rsfr_pkg::RX_DONE: if (!rxDone)
                    rxState <= rsfr_pkg::RX_IDLE;
            endcase
        end
    end

    // completion and timeout flags; hardware set beats software clear
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rxDone <= 1'b0;
            rxTmo <= 1'b0;
        end else if (rxFinish) begin
            // flag rises with the last byte already in memory
            rxDone <= 1'b1;
            rxTmo <= tmoHit;
        end else if (wrEn && isAt(avs_address, `RSFR_CTRL_OFS)
                     && avs_writedata[`RSFR_CTRL_CLRDONE]) begin
            rxDone <= 1'b0;
            // timeout follows the complete flag down
            rxTmo <= 1'b0;
        end
    end

    // memory writes from the bus and from the receiver
    always_ff @(posedge clock) begin
        if (wrEn && avs_address >= `RSFR_MEM_OFS)
            mem[avs_address[9:2]] <= avs_writedata[15:0];
        // arrival order from the destination base
        if (rxState == rsfr_pkg::RX_DATA && rxByte.valid
            && !(fmt[`RSFR_FMT_STOPEN] && rxByte.data == stopChar)) begin
            // byte mode clears the high half
            if (pack)
                mem[wordIdx(rxBase, rxCnt, 1'b1)] <= {8'h00, rxByte.data};
            // even bytes low half, odd bytes high half
            else if (!rxCnt[0])
                mem[wordIdx(rxBase, rxCnt, 1'b0)][7:0] <= rxByte.data;
            else
                mem[wordIdx(rxBase, rxCnt, 1'b0)][15:8] <= rxByte.data;
        end
    end

    // transmit side: next byte can load when the slot is empty or taken
    assign txFree = !txByte.valid || txReady;
    assign txWord = mem[wordIdx(txBase, txCnt, pack)];
    assign txDone = txState == rsfr_pkg::TX_END && txFree;

    // transmit sequencer
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            txState <= rsfr_pkg::TX_IDLE;
            txCnt <= 8'h00;
            txByte <= '0;
        end else begin
            if (txReady)
                txByte.valid <= 1'b0;
            unique case (txState)
                rsfr_pkg::TX_IDLE: if (txReq) begin
                    txCnt <= 8'h00;
                    txState <= rsfr_pkg::TX_START;
                end
                rsfr_pkg::TX_START: if (txFree) begin
                    if (fmt[`RSFR_FMT_STARTEN])
                        txByte <= '{valid: 1'b1, data: startChar};
                    txState <= rsfr_pkg::TX_DATA;
                end
                // exactly txLen bytes from the source base
                rsfr_pkg::TX_DATA: if (txCnt == txLen)
                    txState <= rsfr_pkg::TX_STOP;
                else if (txFree) begin
                    // byte mode drops the high half; otherwise low first
                    txByte <= '{valid: 1'b1,
                                data: (pack || !txCnt[0]) ? txWord[7:0] : txWord[15:8]};
                    txCnt <= txCnt + 8'h01;
                end
                rsfr_pkg::TX_STOP: if (txFree) begin
                    if (fmt[`RSFR_FMT_STOPEN])
                        txByte <= '{valid: 1'b1, data: stopChar};
                    txState <= rsfr_pkg::TX_END;
                end
                // wait for the last byte to be taken
                rsfr_pkg::TX_END: if (txFree)
                    txState <= rsfr_pkg::TX_IDLE;
            endcase
        end
    end

    // request set by software, dropped when the frame is out
    always_ff @(posedge clock) begin
        if (sys_rst)
            txReq <= 1'b0;
        else if (wrEn && isAt(avs_address, `RSFR_CTRL_OFS) && avs_writedata[`RSFR_CTRL_TXREQ])
            txReq <= 1'b1;
        else if (txDone)
            txReq <= 1'b0;
    end

    // sticky interrupt causes; events win over the clear
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            irqStat <= 3'h0;
            irq <= 1'b0;
        end else begin
            irqStat <= (irqStat & ~((wrEn && isAt(avs_address, `RSFR_IRQ_CLR_OFS))
                       ? avs_writedata[2:0] : 3'h0)) | {txDone, tmoHit, rxFinish};
            irq <= |(irqStat & irqEn);
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    run_wait_a: assert property (rxState == rsfr_pkg::RX_IDLE && run && rxLen != 8'h00 && !rxDone
        |=> rxState == rsfr_pkg::RX_HUNT || rxState == rsfr_pkg::RX_DATA)
        else $error("run did not enter receive waiting");
    rewait_a: assert property ($fell(rxDone) && run && rxLen != 8'h00
        |-> ##[1:2] rxState == rsfr_pkg::RX_HUNT || rxState == rsfr_pkg::RX_DATA)
        else $error("no return to waiting after clear");
    zero_len_a: assert property (rxLen == 8'h00 && rxState == rsfr_pkg::RX_IDLE
        |=> rxState == rsfr_pkg::RX_IDLE && !$rose(rxDone))
        else $error("zero length started reception");
    tmo_done_a: assert property ($rose(rxTmo) |-> $rose(rxDone))
        else $error("timeout without completion");
    tmo_clear_a: assert property ($fell(rxDone) |-> !rxTmo)
        else $error("timeout flag outlived complete flag");
    tmo_floor_a: assert property (tmoHit |-> idleTicks >= 8'h05 && (tmoSet < 8'h05
        || idleTicks >= tmoSet)) else $error("timeout before interval");
    max_count_a: assert property (rxState == rsfr_pkg::RX_DATA |-> rxCnt < rxLen)
        else $error("receive count passed maximum");
    tx_count_a: assert property (txState == rsfr_pkg::TX_STOP |-> txCnt == txLen)
        else $error("wrong number of bytes sent");
    tx_req_a: assert property ($fell(txReq) |-> $past(txState) == rsfr_pkg::TX_END)
        else $error("request dropped before frame end");

    rx_stop_c: cover property ($rose(rxDone) && !rxTmo);
    rx_tmo_c: cover property ($rose(rxTmo));
    tx_done_c: cover property (txDone ##1 txState == rsfr_pkg::TX_IDLE);
    irq_c: cover property ($rose(irq));
endmodule // rsfr_engine

// ### hdl/rsfr_pkg.sv
// types shared by the raw serial engine
package rsfr_pkg;
    typedef enum logic [1:0] {RX_IDLE, RX_HUNT, RX_DATA, RX_DONE} rsfr_rx_e;
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP, TX_END} rsfr_tx_e;
    // one byte on the serial side with its qualifier
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } rsfr_byte_s;
endpackage

// ### hdl/rsfr_regs.svh
// register map, fields, reset values and timing of the raw serial engine
`ifndef RSFR_REGS_SVH
`define RSFR_REGS_SVH
`define RSFR_CTRL_OFS     11'h000
`define RSFR_FMT_OFS      11'h004
`define RSFR_CHAR_OFS     11'h008
`define RSFR_TXCFG_OFS    11'h00C
`define RSFR_RXCFG_OFS    11'h010
`define RSFR_TMO_OFS      11'h014
`define RSFR_STAT_OFS     11'h018
`define RSFR_RXCNT_OFS    11'h01C
`define RSFR_IRQ_STAT_OFS 11'h020
`define RSFR_IRQ_EN_OFS   11'h024
`define RSFR_IRQ_CLR_OFS  11'h028
`define RSFR_MEM_OFS      11'h400
`define RSFR_CTRL_RUN     0
`define RSFR_CTRL_PACK    1
`define RSFR_CTRL_TXREQ   2
`define RSFR_CTRL_CLRDONE 3
`define RSFR_FMT_STARTEN  8
`define RSFR_FMT_STOPEN   9
`define RSFR_CHAR_RST     16'h0302
`define RSFR_TMO_RST      8'h00
`define RSFR_TMO_MIN      8'h05
`define RSFR_TICK_MS      10
`define RSFR_DEF_TMO_MS   50
`define RSFR_CLK_KHZ      250000
`define RSFR_IRQ_RXDONE   0
`define RSFR_IRQ_TMO      1
`define RSFR_IRQ_TXDONE   2
`endif

// ### tb/raw_serial_rx_tx_framing_tb.sv
// self-checking bench for the raw serial engine
`timescale 1ns/1ns
`include "rsfr_regs.svh"
module raw_serial_rx_tx_framing_tb;
    logic                 clock;                 // 250 MHz
    logic                 sys_rst;               // sync reset
    logic [10:0]          avs_address;           // bus address
    logic                 avs_read;              // read strobe
    logic                 avs_write;             // write strobe
    logic [31:0]          avs_writedata;         // write data
    logic [31:0]          avs_readdata;          // read data
    logic                 avs_waitrequest;       // slave stall
    rsfr_pkg::rsfr_byte_s rxByte;                // peer to engine
    rsfr_pkg::rsfr_byte_s txByte;                // engine to peer
    logic                 txReady;               // peer accept
    logic                 irq;                   // level interrupt
    logic [31:0]          rd;                    // last word read
    int                   bad_count = 0;
    int                   check_count = 0;
    always #2 clock = ~clock;
    // short tick keeps timeout runs to a few hundred cycles
    rsfr_engine #(.TICK_CYCLES(20)) dut_u (
        .clock(clock), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .rxByte(rxByte), .txByte(txByte), .txReady(txReady), .irq(irq));
    rsfr_peer peer_u (.txByte(txByte), .clock(clock), .rxByte(rxByte), .txReady(txReady));
    // compare and count
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, exp, got);
        end
    endtask
    // one bus access; an edge passes first so strobes are never set twice in a step
    task automatic bus(input logic wr, input logic [10:0] a, input logic [31:0] d);
        @(posedge clock);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= ~wr;
        avs_write     <= wr;
        @(posedge clock);
        while (avs_waitrequest !== 1'b0) @(posedge clock);
        if (!wr) rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rdchk(input string n, input logic [10:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(n, rd, exp);
    endtask
    function automatic logic [10:0] ma(input int i);
        return `RSFR_MEM_OFS + 11'(i * 4);
    endfunction
    // stop, configure, then run with a fresh completion flag
    task automatic rx_start(input logic pk, input logic [31:0] fmt, input logic [7:0] dst, input logic [7:0] mx);
        bus(1'b1, `RSFR_CTRL_OFS, 32'h0);
        bus(1'b1, `RSFR_FMT_OFS, fmt);
        bus(1'b1, `RSFR_RXCFG_OFS, {16'h0, mx, dst});
        bus(1'b1, `RSFR_IRQ_CLR_OFS, 32'h7);
        bus(1'b1, `RSFR_CTRL_OFS, {28'h0, 4'h9} | {30'h0, pk, 1'b0});
        // leaving the done state takes two edges; bytes before that are dropped
        repeat (2) @(posedge clock);
    endtask
    task automatic t_reset();
        rdchk("char", `RSFR_CHAR_OFS, 32'h0302);
        rdchk("tmo", `RSFR_TMO_OFS, 32'h0);
        rdchk("stat", `RSFR_STAT_OFS, 32'h0);
        rdchk("unmapped", 11'h030, 32'h0);
        chk("irq", {31'h0, irq}, 32'h0);
        $display("test reset done");
    endtask
    // word packing, count limit, extra byte dropped, irq raise and clear
    task automatic t_rxword();
        bus(1'b1, ma(5), 32'hFFFF);
        bus(1'b1, `RSFR_IRQ_EN_OFS, 32'h1);
        rx_start(1'b0, 32'h0, 8'd4, 8'd3);
        rdchk("waiting", `RSFR_STAT_OFS, 32'h8);
        peer_u.send(8'h41);
        peer_u.send(8'h42);
        peer_u.send(8'h43);
        peer_u.send(8'h44);
        rdchk("word4", ma(4), 32'h4241);
        rdchk("word5", ma(5), 32'hFF43);
        rdchk("count", `RSFR_RXCNT_OFS, 32'h3);
        rdchk("done", `RSFR_STAT_OFS, 32'h1);
        chk("irq set", {31'h0, irq}, 32'h1);
        bus(1'b1, `RSFR_IRQ_CLR_OFS, 32'h1);
        repeat (2) @(posedge clock);
        chk("irq clr", {31'h0, irq}, 32'h0);
        bus(1'b1, `RSFR_IRQ_EN_OFS, 32'h0);
        bus(1'b1, `RSFR_CTRL_OFS, 32'h9);
        // done to idle to waiting is two edges after the clear
        repeat (2) @(posedge clock);
        rdchk("rewait", `RSFR_STAT_OFS, 32'h8);
        $display("test rx word done");
    endtask
    // byte packing with start and stop characters, noise before start
    task automatic t_rxbyte();
        bus(1'b1, ma(10), 32'hFFFF);
        bus(1'b1, ma(11), 32'hFFFF);
        rx_start(1'b1, 32'h300, 8'd10, 8'd8);
        peer_u.send(8'h55);
        peer_u.send(8'h02);
        peer_u.send(8'h61);
        peer_u.send(8'h62);
        peer_u.send(8'h03);
        peer_u.send(8'h64);
        rdchk("byte10", ma(10), 32'h0061);
        rdchk("byte11", ma(11), 32'h0062);
        rdchk("count", `RSFR_RXCNT_OFS, 32'h2);
        rdchk("stopped", `RSFR_STAT_OFS, 32'h1);
        $display("test rx byte done");
    endtask
    // idle gap completes reception; quiet and late spans bracket the interval
    task automatic t_timeout(input logic [7:0] st, input int quiet, input int late);
        bus(1'b1, `RSFR_TMO_OFS, {24'h0, st});
        rx_start(1'b0, 32'h0, 8'd40, 8'd10);
        peer_u.send(8'h77);
        repeat (quiet) @(posedge clock);
        rdchk("early", `RSFR_STAT_OFS, 32'h8);
        repeat (late - quiet) @(posedge clock);
        rdchk("expired", `RSFR_STAT_OFS, 32'h3);
        bus(1'b1, `RSFR_CTRL_OFS, 32'h9);
        repeat (2) @(posedge clock);
        rdchk("cleared", `RSFR_STAT_OFS, 32'h8);
        $display("test timeout %0d done", st);
    endtask
    task automatic t_zero();
        rx_start(1'b0, 32'h0, 8'd50, 8'd0);
        rdchk("nowait", `RSFR_STAT_OFS, 32'h0);
        peer_u.send(8'h12);
        rdchk("noflag", `RSFR_STAT_OFS, 32'h0);
        $display("test zero length done");
    endtask
    // send n bytes from word src and compare what the peer took
    task automatic t_tx(input logic pk, input logic [31:0] fmt, input int src, input int n, input logic [7:0] e[$]);
        peer_u.seen.delete();
        bus(1'b1, `RSFR_IRQ_CLR_OFS, 32'h7);
        bus(1'b1, `RSFR_FMT_OFS, fmt);
        bus(1'b1, `RSFR_TXCFG_OFS, {16'h0, 8'(n), 8'(src)});
        bus(1'b1, `RSFR_CTRL_OFS, {29'h0, 1'b1, 1'b0, 1'b1} | {30'h0, pk, 1'b0});
        rd = 32'h4;
        for (int k = 0; k < 200 && rd[2] !== 1'b0; k++) bus(1'b0, `RSFR_STAT_OFS, 32'h0);
        chk("txreq", {31'h0, rd[2]}, 32'h0);
        chk("txlen", peer_u.seen.size(), e.size());
        for (int k = 0; k < e.size() && k < peer_u.seen.size(); k++) chk("txbyte", peer_u.seen[k], e[k]);
        bus(1'b0, `RSFR_IRQ_STAT_OFS, 32'h0);
        chk("txirq", rd & 32'h4, 32'h4);
        $display("test tx %0d done", src);
    endtask
    initial begin
        // idle bus levels; reset held for ten edges
        clock = 1'b0;
        sys_rst <= 1'b1;
        avs_address <= 11'h000;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_writedata <= 32'h0000_0000;
        repeat (10) @(posedge clock);
        sys_rst <= 1'b0;
        t_reset();
        t_rxword();
        t_rxbyte();
        t_timeout(8'd9, 140, 210);
        t_timeout(8'd0, 70, 130);
        t_zero();
        bus(1'b1, `RSFR_CHAR_OFS, 32'h7E5A);
        bus(1'b1, ma(20), 32'h1211);
        bus(1'b1, ma(21), 32'h1413);
        peer_u.slow = 1'b1;
        t_tx(1'b0, 32'h300, 20, 3, '{8'h5A, 8'h11, 8'h12, 8'h13, 8'h7E});
        bus(1'b1, ma(30), 32'hAB31);
        bus(1'b1, ma(31), 32'hCD32);
        peer_u.slow = 1'b0;
        t_tx(1'b1, 32'h0, 30, 2, '{8'h31, 8'h32});
        report_and_stop();
    end
    // hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        bad_count++;
        report_and_stop();
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
endmodule // raw_serial_rx_tx_framing_tb

// ### tb/rsfr_peer.sv
// serial peer model facing the raw serial engine
`timescale 1ns/1ns
module rsfr_peer (
    input  wire rsfr_pkg::rsfr_byte_s txByte,
    input  wire logic                 clock,
    output rsfr_pkg::rsfr_byte_s      rxByte,
    output logic                      txReady
);
    logic       slow = 1'b0;   // stall every other cycle when set
    logic       phase = 1'b0;  // stall pacing
    logic [7:0] seen[$];       // bytes taken from the engine
    initial begin
        rxByte = '{1'b0, 8'hFF};
        txReady = 1'b0;
    end
    // take one byte per accepted edge, in order
    always @(posedge clock) begin
        if (txByte.valid === 1'b1 && txReady === 1'b1) seen.push_back(txByte.data);
        phase   <= ~phase;
        txReady <= ~slow | phase;
    end
    // one valid pulse per byte; idle data inverted so stale bytes never match
    task automatic send(input logic [7:0] b);
        @(posedge clock);
        rxByte <= '{1'b1, b};
        @(posedge clock);
        rxByte <= '{1'b0, ~b};
    endtask
endmodule // rsfr_peer
